// >>> hdl/msd_consts.svh
`ifndef MSD_CONSTS_SVH
`define MSD_CONSTS_SVH
// register byte addresses
`define MSD_ADDR_SET 8'h00
`define MSD_ADDR_MODE 8'h04
`define MSD_ADDR_SPA 8'h08
`define MSD_ADDR_SPB 8'h0C
`define MSD_ADDR_SPC 8'h10
`define MSD_ADDR_STAT 8'h14
// setting word fields
`define MSD_CON_LO 0
`define MSD_CON_HI 1
`define MSD_CON_SW 2
`define MSD_TTYPE 3
`define MSD_BRK_EN 4
`define MSD_GRACE_LO 5
`define MSD_GRACE_HI 7
`define MSD_FLASH_WP 8
`define MSD_DBG_LO 12
`define MSD_DBG_HI 13
`define MSD_DBG_SW 14
// reset values
`define MSD_SET_RST 16'h0000
`define MSD_MODE_RST 16'h0000
// mode word limits
`define MSD_MODE_LAST_RUN 16'h0001
`define MSD_MODE_LAST_DBG 16'h0003
`define MSD_MODE_PROG 16'h0004
// timing
`define MSD_CLK_HZ 20000000
`define MSD_GRACE_UNIT_US 100
`define MSD_GRACE_UNIT_CYC ((`MSD_CLK_HZ / 1000000) * `MSD_GRACE_UNIT_US)
`endif

// >>> hdl/msd_pkg.sv
`default_nettype none
package msd_pkg;
	typedef enum logic [1:0]
	{
		MSD_CH_NONE,
		MSD_SERIAL_CHANNEL_ONE,
		MSD_SERIAL_CHANNEL_TWO
	} msd_chan_t;
	typedef enum logic [1:0]
	{
		MSD_MODE_RUN,
		MSD_MODE_DEBUG,
		MSD_MODE_PROGRAM,
		MSD_MODE_NONE
	} msd_mode_t;
	typedef enum logic
	{
		MSD_TERMINAL_TYPE_FIRST,
		MSD_TERMINAL_TYPE_SECOND
	} msd_term_t;
	typedef enum logic
	{
		MSD_RST_IDLE,
		MSD_RST_WAIT
	} msd_rst_state_t;
	typedef struct packed {
		logic dbg_sw;
		logic con_sw;
		logic brk_en;
		msd_term_t term;
		logic flash_wp;
		logic rst_pend;
		logic sys_mode;
		logic cfg_err;
		msd_mode_t mode;
		msd_chan_t dbg_ch;
		msd_chan_t con_ch;
	} msd_cfg_t;
endpackage
`default_nettype wire

// >>> hdl/msd_top.sv
// The address map and the APB register port were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "msd_consts.svh"
module msd_top
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// device events
	input wire logic reset_request_i,
	input wire logic break_key_i,
	input wire logic multitask_run_i,
	input wire logic flash_wr_req_i,
	// decoded state
	output var msd_pkg::msd_cfg_t cfg_o,
	output logic reset_op_o,
	output logic flash_wr_grant_o,
	output logic flash_wr_refused_o
);
	// ****************************************
	// declarations
	// ****************************************
	logic [15:0] set_q;
	logic [15:0] mode_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic wr_en;
	logic setup;
	logic hit;
	logic [31:0] rd_data;
	msd_pkg::msd_cfg_t cfg_q;
	msd_pkg::msd_cfg_t dec;
	logic sys_mode_q;
	logic brk_take;
	logic req_prev_q;
	logic req_rise;
	msd_pkg::msd_rst_state_t rst_st_q;
	logic [15:0] cnt_q;
	logic [15:0] grace_load;
	logic reset_op_q;
	logic grant_q;
	logic refused_q;
	logic [15:0] wr_mask;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	// ****************************************
	// apb slave
	// ****************************************
	assign setup = psel_i && !penable_i;
	assign wr_en = psel_i && penable_i && pwrite_i && pready_q;
	assign wr_mask = {{8{pstrb_i[1]}}, {8{pstrb_i[0]}}};

	always_comb
	begin
		hit = 1'b1;
		rd_data = 32'h00000000;
		unique case (paddr_i)
			`MSD_ADDR_SET: rd_data = {16'h0000, set_q};
			`MSD_ADDR_MODE: rd_data = {16'h0000, mode_q};
			`MSD_ADDR_SPA,
			`MSD_ADDR_SPB,
			`MSD_ADDR_SPC: rd_data = 32'h00000000;
			`MSD_ADDR_STAT: rd_data = {18'h00000, cfg_q};
			default: hit = 1'b0;
		endcase
	end

	// zero wait state: answer in the access cycle, also while reset waits
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end
		else
		begin
			pready_q <= setup;
			pslverr_q <= setup && !hit;
			if (setup)
			begin
				prdata_q <= pwrite_i ? 32'h00000000 : rd_data;
			end
		end
	end

	// switch word storage with byte strobes
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			set_q <= `MSD_SET_RST;
			mode_q <= `MSD_MODE_RST;
		end
		else if (wr_en && !pslverr_q)
		begin
			if (paddr_i == `MSD_ADDR_SET)
			begin
				set_q <= set_q & ~wr_mask | pwdata_i[15:0] & wr_mask;
			end
			if (paddr_i == `MSD_ADDR_MODE)
			begin
				mode_q <= mode_q & ~wr_mask | pwdata_i[15:0] & wr_mask;
			end
		end
	end

	// ****************************************
	// setting decode
	// ****************************************
	function automatic msd_pkg::msd_chan_t chan_dec(input logic [1:0] f);
		msd_pkg::msd_chan_t c;
		unique case (f)
			2'h1: c = msd_pkg::MSD_SERIAL_CHANNEL_ONE;
			2'h2: c = msd_pkg::MSD_SERIAL_CHANNEL_TWO;
			default: c = msd_pkg::MSD_CH_NONE;
		endcase
		return c;
	endfunction

	always_comb
	begin
		dec = cfg_q;
		dec.con_ch = chan_dec(set_q[`MSD_CON_HI:`MSD_CON_LO]);
		dec.dbg_ch = chan_dec(set_q[`MSD_DBG_HI:`MSD_DBG_LO]);
		dec.con_sw = set_q[`MSD_CON_SW];
		dec.dbg_sw = set_q[`MSD_DBG_SW];
		dec.term = msd_pkg::msd_term_t'(set_q[`MSD_TTYPE]);
		dec.brk_en = set_q[`MSD_BRK_EN];
		dec.flash_wp = set_q[`MSD_FLASH_WP];
		if (mode_q <= `MSD_MODE_LAST_RUN)
		begin
			dec.mode = msd_pkg::MSD_MODE_RUN;
		end
		else if (mode_q <= `MSD_MODE_LAST_DBG)
		begin
			dec.mode = msd_pkg::MSD_MODE_DEBUG;
		end
		else if (mode_q == `MSD_MODE_PROG)
		begin
			dec.mode = msd_pkg::MSD_MODE_PROGRAM;
		end
		else
		begin
			dec.mode = msd_pkg::MSD_MODE_NONE;
		end
		dec.cfg_err = (set_q[`MSD_CON_HI:`MSD_CON_LO] == 2'h3)
			|| (set_q[`MSD_DBG_HI:`MSD_DBG_LO] == 2'h3)
			|| (mode_q > `MSD_MODE_PROG);
		dec.sys_mode = sys_mode_q;
		dec.rst_pend = (rst_st_q == msd_pkg::MSD_RST_WAIT);
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cfg_q <= '0;
		end
		else
		begin
			cfg_q <= dec;
		end
	end

	// ****************************************
	// break key handling
	// ****************************************
	assign brk_take = break_key_i && dec.brk_en && multitask_run_i
		&& (dec.mode == msd_pkg::MSD_MODE_RUN) && !dec.cfg_err;

	// a break in the same cycle as the reset start wins
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			sys_mode_q <= 1'b0;
		end
		else if (brk_take)
		begin
			sys_mode_q <= 1'b1;
		end
		else if (reset_op_q)
		begin
			sys_mode_q <= 1'b0;
		end
	end

	// ****************************************
	// reset request grace interval
	// ****************************************
	assign req_rise = reset_request_i && !req_prev_q;
	assign grace_load = 16'(set_q[`MSD_GRACE_HI:`MSD_GRACE_LO]
		* `MSD_GRACE_UNIT_CYC);

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			req_prev_q <= 1'b0;
			rst_st_q <= msd_pkg::MSD_RST_IDLE;
			cnt_q <= 16'h0000;
			reset_op_q <= 1'b0;
		end
		else
		begin
			req_prev_q <= reset_request_i;
			reset_op_q <= 1'b0;
			unique case (rst_st_q)
				msd_pkg::MSD_RST_IDLE:
				begin
					if (req_rise)
					begin
						rst_st_q <= msd_pkg::MSD_RST_WAIT;
						cnt_q <= grace_load;
					end
				end
				msd_pkg::MSD_RST_WAIT:
				begin
					if (cnt_q == 16'h0000)
					begin
						reset_op_q <= 1'b1;
						rst_st_q <= msd_pkg::MSD_RST_IDLE;
					end
					else
					begin
						cnt_q <= cnt_q - 16'h0001;
					end
				end
			endcase
		end
	end

	// ****************************************
	// flash write protection
	// ****************************************
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			grant_q <= 1'b0;
			refused_q <= 1'b0;
		end
		else
		begin
			grant_q <= flash_wr_req_i && !dec.flash_wp;
			refused_q <= flash_wr_req_i && dec.flash_wp;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign prdata_o = prdata_q;
	assign pready_o = pready_q;
	assign pslverr_o = pslverr_q;
	assign cfg_o = cfg_q;
	assign reset_op_o = reset_op_q;
	assign flash_wr_grant_o = grant_q;
	assign flash_wr_refused_o = refused_q;

	// ****************************************
	// assertions
	// ****************************************
	rd_upper_zero_a: assert property (
		pready_o |-> prdata_o[31:16] == 16'h0000)
		else $error("upper read data not zero");
	con_illegal_a: assert property (
		set_q[1:0] == 2'h3 |=> cfg_o.cfg_err
			&& cfg_o.con_ch == msd_pkg::MSD_CH_NONE)
		else $error("illegal console channel not flagged");
	dbg_chan_a: assert property (
		set_q[13:12] == 2'h2 |=>
			cfg_o.dbg_ch == msd_pkg::MSD_SERIAL_CHANNEL_TWO)
		else $error("debugger channel decode wrong");
	term_sw_a: assert property (
		set_q[3] && set_q[2] |=> cfg_o.con_sw
			&& cfg_o.term == msd_pkg::MSD_TERMINAL_TYPE_SECOND)
		else $error("terminal or software setting wrong");
	mode_bad_a: assert property (
		mode_q > 16'h0004 |=> cfg_o.cfg_err
			&& cfg_o.mode == msd_pkg::MSD_MODE_NONE)
		else $error("prohibited mode not flagged");
	mode_debug_a: assert property (
		mode_q inside {16'h0002, 16'h0003} |=>
			cfg_o.mode == msd_pkg::MSD_MODE_DEBUG && !cfg_o.cfg_err
			|| set_q[1:0] == 2'h3 || set_q[13:12] == 2'h3)
		else $error("debug mode decode wrong");
	brk_stop_a: assert property (
		brk_take |=> sys_mode_q ##1 cfg_o.sys_mode)
		else $error("break key did not enter system mode");
	brk_ignore_a: assert property (
		!sys_mode_q && (!set_q[4] || mode_q > 16'h0001) |=> !sys_mode_q)
		else $error("break key taken while disabled");
	flash_ref_a: assert property (
		flash_wr_req_i && set_q[8] |=> flash_wr_refused_o
			&& !flash_wr_grant_o)
		else $error("protected flash write not refused");
	grace_zero_a: assert property (
		rst_st_q == msd_pkg::MSD_RST_IDLE && req_rise
			&& set_q[7:5] == 3'h0 |=> ##1 reset_op_o)
		else $error("zero grace reset start late");
	grace_count_a: assert property (
		rst_st_q == msd_pkg::MSD_RST_WAIT && cnt_q != 16'h0000 |=>
			!reset_op_o && cnt_q == $past(cnt_q) - 16'h0001)
		else $error("grace counter misbehaves");
	grace_apb_a: assert property (
		setup && rst_st_q == msd_pkg::MSD_RST_WAIT |=> pready_o)
		else $error("apb stalled during grace interval");
endmodule
`default_nettype wire

// >>> sim/msd_cpu_model.sv
`timescale 1ns/1ns
`default_nettype none
module msd_cpu_model
(
	// clock
	input wire logic clk_i,
	// apb master
	output var logic psel_o,
	output var logic penable_o,
	output var logic pwrite_o,
	output var logic [7:0] paddr_o,
	output var logic [31:0] pwdata_o,
	output var logic [3:0] pstrb_o,
	input wire logic [31:0] prdata_i,
	input wire logic pready_i,
	input wire logic pslverr_i
);
	initial
	begin
		psel_o = 1'b0;
		penable_o = 1'b0;
		pwrite_o = 1'b0;
		paddr_o = 8'h00;
		pwdata_o = 32'h00000000;
		pstrb_o = 4'h0;
	end
	// one apb transfer, held until pready
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge clk_i);
		psel_o <= 1'b1;
		pwrite_o <= w;
		paddr_o <= a;
		pwdata_o <= d;
		pstrb_o <= 4'h3;
		@(posedge clk_i);
		penable_o <= 1'b1;
		do @(posedge clk_i); while (pready_i !== 1'b1);
		r = prdata_i;
		e = pslverr_i;
		psel_o <= 1'b0;
		penable_o <= 1'b0;
		paddr_o <= ~a;
		pwdata_o <= ~d;
	endtask
	// spare words get zero
	task clear_spares(output logic [31:0] r, output logic e);
		for (int i = 0; i < 3; i++)
			xfer(1'b1, 8'h08 + 8'(4 * i), 32'h00000000, r, e);
	endtask
endmodule
`default_nettype wire

// >>> sim/tb_msd_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "msd_consts.svh"
module tb_msd_top;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic psel_i, penable_i, pwrite_i, pready_o, pslverr_o, err;
	logic [7:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o, rd;
	logic [3:0] pstrb_i;
	logic reset_request_i = 1'b0;
	logic break_key_i = 1'b0;
	logic multitask_run_i = 1'b0;
	logic flash_wr_req_i = 1'b0;
	logic reset_op_o, flash_wr_grant_o, flash_wr_refused_o;
	msd_pkg::msd_cfg_t cfg_o;
	int fail_count = 0;
	int checks_done = 0;
	always #25 clk_i = ~clk_i;
	msd_top dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
		.pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o),
		.reset_request_i(reset_request_i), .break_key_i(break_key_i),
		.multitask_run_i(multitask_run_i), .flash_wr_req_i(flash_wr_req_i),
		.cfg_o(cfg_o), .reset_op_o(reset_op_o),
		.flash_wr_grant_o(flash_wr_grant_o),
		.flash_wr_refused_o(flash_wr_refused_o));
	msd_cpu_model cpu (.clk_i(clk_i), .psel_o(psel_i), .penable_o(penable_i),
		.pwrite_o(pwrite_i), .paddr_o(paddr_i), .pwdata_o(pwdata_i),
		.pstrb_o(pstrb_i), .prdata_i(prdata_o), .pready_i(pready_o),
		.pslverr_i(pslverr_o));
	// ***************
	// helpers
	// ***************
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		checks_done++;
		if (s !== e)
		begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task wr(input logic [7:0] a, input logic [15:0] d);
		cpu.xfer(1'b1, a, {16'h0000, d}, rd, err);
		cyc(2);
	endtask
	task rdc(input string n, input logic [7:0] a, input logic [31:0] e);
		cpu.xfer(1'b0, a, 32'h00000000, rd, err);
		chk(n, e, rd);
	endtask
	task pulse_brk;
		@(posedge clk_i);
		break_key_i <= 1'b1;
		@(posedge clk_i);
		break_key_i <= 1'b0;
		cyc(3);
	endtask
	task flash(input logic prot);
		logic g, r;
		g = 1'b0;
		r = 1'b0;
		@(posedge clk_i);
		flash_wr_req_i <= 1'b1;
		@(posedge clk_i);
		flash_wr_req_i <= 1'b0;
		repeat (3)
		begin
			@(posedge clk_i);
			g = g | flash_wr_grant_o;
			r = r | flash_wr_refused_o;
		end
		chk("flash_refused", prot, r);
		chk("flash_grant", !prot, g);
	endtask
	// ***************
	// scenarios
	// ***************
	task t_reset;
		cpu.clear_spares(rd, err);
		rdc("set_rst", `MSD_ADDR_SET, 32'h00000000);
		rdc("mode_rst", `MSD_ADDR_MODE, 32'h00000000);
		rdc("spare", `MSD_ADDR_SPB, 32'h00000000);
		chk("slverr_ok", 1'b0, err);
		rdc("stat_rst", `MSD_ADDR_STAT, 32'h00000000);
		rdc("unmapped", 8'h20, 32'h00000000);
		chk("slverr", 1'b1, err);
	endtask
	task t_fields;
		wr(`MSD_ADDR_SET, 16'h611D);
		chk("con_ch", msd_pkg::MSD_SERIAL_CHANNEL_ONE, cfg_o.con_ch);
		chk("dbg_ch", msd_pkg::MSD_SERIAL_CHANNEL_TWO, cfg_o.dbg_ch);
		chk("sw", 2'b11, {cfg_o.con_sw, cfg_o.dbg_sw});
		chk("term", msd_pkg::MSD_TERMINAL_TYPE_SECOND, cfg_o.term);
		chk("wp", 1'b1, cfg_o.flash_wp);
		rdc("set_rb", `MSD_ADDR_SET, 32'h0000611D);
		flash(1'b1);
		wr(`MSD_ADDR_SET, 16'h3003);
		chk("bad_ch", 4'h0, {cfg_o.dbg_ch, cfg_o.con_ch});
		chk("bad_err", 1'b1, cfg_o.cfg_err);
		wr(`MSD_ADDR_SET, 16'h0000);
		flash(1'b0);
	endtask
	task t_mode;
		logic [1:0] e;
		for (int m = 0; m < 7; m++)
		begin
			wr(`MSD_ADDR_MODE, (m == 6) ? 16'h0010 : 16'(m));
			e = (m < 2) ? msd_pkg::MSD_MODE_RUN : (m < 4) ?
				msd_pkg::MSD_MODE_DEBUG : (m == 4) ?
				msd_pkg::MSD_MODE_PROGRAM : msd_pkg::MSD_MODE_NONE;
			chk("mode", e, cfg_o.mode);
			chk("mode_err", m > 4, cfg_o.cfg_err);
		end
		wr(`MSD_ADDR_MODE, 16'h0000);
	endtask
	task t_brk;
		multitask_run_i <= 1'b1;
		pulse_brk;
		chk("brk_off", 1'b0, cfg_o.sys_mode);
		wr(`MSD_ADDR_SET, 16'h0030);
		chk("brk_en", 1'b1, cfg_o.brk_en);
		wr(`MSD_ADDR_MODE, 16'h0002);
		pulse_brk;
		chk("brk_dbg", 1'b0, cfg_o.sys_mode);
		wr(`MSD_ADDR_MODE, 16'h0000);
		multitask_run_i <= 1'b0;
		pulse_brk;
		chk("brk_idle", 1'b0, cfg_o.sys_mode);
		multitask_run_i <= 1'b1;
		pulse_brk;
		chk("brk_on", 1'b1, cfg_o.sys_mode);
	endtask
	task t_grace;
		time t0;
		int n;
		@(posedge clk_i);
		reset_request_i <= 1'b1;
		t0 = $time;
		wr(`MSD_ADDR_MODE, 16'h0001);
		rdc("grace_rd", `MSD_ADDR_MODE, 32'h00000001);
		chk("pend", 1'b1, cfg_o.rst_pend);
		n = 0;
		while (reset_op_o !== 1'b1 && n < 3000)
		begin
			@(posedge clk_i);
			n++;
		end
		n = int'(($time - t0) / 50);
		chk("grace_len", 1'b1, n >= 2000 && n <= 2006);
		cyc(3);
		chk("sys_clr", 1'b0, cfg_o.sys_mode);
		reset_request_i <= 1'b0;
		wr(`MSD_ADDR_SET, 16'h0000);
		@(posedge clk_i);
		reset_request_i <= 1'b1;
		n = 0;
		while (reset_op_o !== 1'b1 && n < 10)
		begin
			@(posedge clk_i);
			n++;
		end
		chk("grace_zero", 32'h00000003, n);
		reset_request_i <= 1'b0;
	endtask
	task report_and_stop;
		$display("fail_count %0d checks_done %0d", fail_count, checks_done);
		if (fail_count == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		cyc(2);
		rst_n_i <= 1'b1;
		t_reset;
		t_fields;
		t_mode;
		t_brk;
		t_grace;
		report_and_stop;
	end
	initial
	begin
		#2000000;
		fail_count++;
		report_and_stop;
	end
endmodule
`default_nettype wire
